// >>> design/usb_port_pkg.sv
package usb_port_pkg;

    // Register byte addresses of the two serial engines.
    localparam logic [15:0] ADDR_HOST_CTRL_1 = 16'hc080;
    localparam logic [15:0] ADDR_PORT_CTRL_1 = 16'hc08a;
    localparam logic [15:0] ADDR_HOST_CTRL_2 = 16'hc0a0;
    localparam logic [15:0] ADDR_PORT_CTRL_2 = 16'hc0aa;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Field positions of the port line control register.
    localparam int PLC_DP_BIT = 13;
    localparam int PLC_DM_BIT = 12;
    localparam int PLC_LOW_SPEED_BIT = 10;
    localparam int PLC_HOST_ROLE_BIT = 9;
    localparam int PLC_RES_EN_BIT = 7;
    localparam int PLC_FORCE_HI_BIT = 4;
    localparam int PLC_FORCE_LO_BIT = 3;
    localparam int PLC_SUSPEND_BIT = 2;
    localparam int PLC_MARKER_EN_BIT = 0;

    // Field positions of the host transaction control register.
    localparam int HTC_PREAMBLE_BIT = 7;
    localparam int HTC_SEQ_BIT = 6;
    localparam int HTC_SYNC_BIT = 5;
    localparam int HTC_ISO_BIT = 4;
    localparam int HTC_ARM_BIT = 0;

    // Line force field encodings.
    typedef enum logic [1:0] {
        FORCE_NORMAL = 2'h0,
        FORCE_SE0 = 2'h1,
        FORCE_J = 2'h2,
        FORCE_K = 2'h3
    } line_force_t;

    // Host transaction sequencer states.
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_MARKER = 2'h1,
        SEQ_PREAMBLE = 2'h2,
        SEQ_PACKET = 2'h3
    } seq_state_t;

    // Frame period and the clock rate it is counted in.
    localparam int FRAME_PERIOD_US = 1000;
    localparam int CLOCK_MHZ = 200;
    localparam int FRAME_CYCLES = FRAME_PERIOD_US * CLOCK_MHZ;

endpackage

// >>> design/line_sync.sv
`timescale 1ns/1ps
module line_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t syncState_r;
    sync_state_t syncState_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        syncState_nxt.stage1 = asyncIn;
        syncState_nxt.stage2 = syncState_r.stage1;
    end

    // Both stages clear to zero on reset.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            syncState_r <= '0;
        end else begin
            syncState_r <= syncState_nxt;
        end
    end

    assign syncOut = syncState_r.stage2;

endmodule

// >>> design/frame_timer.sv
`timescale 1ns/1ps
module frame_timer #(
    parameter int FRAME_CYCLES = usb_port_pkg::FRAME_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // One-cycle pulse at the start of every frame.
    output logic frameTick
);

    localparam int CW = $clog2(FRAME_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(FRAME_CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic tick;
    } timer_state_t;

    timer_state_t timer_r;
    timer_state_t timer_nxt;

    // Free running frame divider.
    always_comb begin
        timer_nxt = timer_r;
        timer_nxt.tick = 1'b0;
        if (timer_r.count == LAST) begin
            timer_nxt.count = '0;
            timer_nxt.tick = 1'b1;
        end else begin
            timer_nxt.count = timer_r.count + CW'(1);
        end
    end

    // Register the divider state.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            timer_r <= '0;
        end else begin
            timer_r <= timer_nxt;
        end
    end

    assign frameTick = timer_r.tick;

endmodule

// >>> design/usb_port_line_and_host_control.sv
`timescale 1ns/1ps
module usb_port_line_and_host_control #(
    parameter int FRAME_CYCLES = usb_port_pkg::FRAME_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // On-chip processor register port.
    input wire logic cpuSel,
    input wire logic cpuWrite,
    input wire logic [15:0] cpuAddr,
    input wire logic [15:0] cpuWriteData,
    output logic [15:0] cpuReadData,
    // External processor port register access.
    input wire logic hpiSel,
    input wire logic hpiWrite,
    input wire logic [15:0] hpiAddr,
    input wire logic [15:0] hpiWriteData,
    output logic [15:0] hpiReadData,
    // Port A data line pins, one per engine.
    input wire logic [1:0] dpIn,
    input wire logic [1:0] dmIn,
    output logic [1:0] dpOut,
    output logic [1:0] dmOut,
    output logic [1:0] lineOeN,
    // Termination resistor controls.
    output logic [1:0] pullDownDp,
    output logic [1:0] pullDownDm,
    output logic [1:0] pullUpDp,
    output logic [1:0] pullUpDm,
    // Transceiver power and receive gating.
    output logic [1:0] xcvrPowerDown,
    output logic [1:0] rxEnable,
    // Active port selection, high selects port B.
    input wire logic [1:0] portSelectB,
    // Packet engine drive and handshake.
    input wire logic [1:0] txDp,
    input wire logic [1:0] txDm,
    input wire logic [1:0] txActive,
    input wire logic [1:0] pktDone,
    output logic [1:0] pktStart,
    output logic [1:0] preambleStart,
    output logic [1:0] markerStart,
    output logic [1:0] markerEop,
    output logic [1:0] pktToggle,
    output logic [1:0] pktIso
);

    typedef struct packed {
        logic [1:0] lowSpeed;
        logic [1:0] hostRole;
        logic [1:0] resEn;
        logic [1:0][1:0] lineForce;
        logic [1:0] suspend;
        logic [1:0] markerEn;
        logic [1:0] preamble;
        logic [1:0] seqSel;
        logic [1:0] syncEn;
        logic [1:0] isoEn;
        logic [1:0] arm;
        logic [1:0] markerPending;
        logic [1:0] syncReady;
        logic [1:0][1:0] state;
        logic [1:0] pktStart;
        logic [1:0] preStart;
        logic [1:0] mrkStart;
        logic [1:0] mrkEop;
        logic [1:0] toggle;
        logic [1:0] iso;
        logic [1:0] dpDrv;
        logic [1:0] dmDrv;
        logic [1:0] oeN;
        logic [1:0] rxEn;
        logic [1:0] pdDp;
        logic [1:0] pdDm;
        logic [1:0] puDp;
        logic [1:0] puDm;
        logic [15:0] cpuRd;
        logic [15:0] hpiRd;
    } ctrl_state_t;

    ctrl_state_t r;
    ctrl_state_t n;
    logic [3:0] lineSync;
    logic frameTick;

    // Two-stage synchroniser for the four sampled line levels.
    line_sync #(.WIDTH(4)) lineSyncInst (
        .clock(clock),
        .sys_rst(sys_rst),
        .asyncIn({dmIn, dpIn}),
        .syncOut(lineSync)
    );

    // Frame period divider shared by both engines.
    frame_timer #(.FRAME_CYCLES(FRAME_CYCLES)) frameTimerInst (
        .clock(clock),
        .sys_rst(sys_rst),
        .frameTick(frameTick)
    );

    // Decodes an address into valid, engine index and port-control select.
    function automatic logic [2:0] decodeAddr(input logic [15:0] addr);
        logic [2:0] code;
        code = 3'h0;
        unique case (addr)
            usb_port_pkg::ADDR_HOST_CTRL_1: code = 3'h4;
            usb_port_pkg::ADDR_PORT_CTRL_1: code = 3'h5;
            usb_port_pkg::ADDR_HOST_CTRL_2: code = 3'h6;
            usb_port_pkg::ADDR_PORT_CTRL_2: code = 3'h7;
            default: code = 3'h0;
        endcase
        return code;
    endfunction

    // Builds the read value of a decoded register; unmapped reads give zero.
    function automatic logic [15:0] readReg(input ctrl_state_t s, input logic [2:0] code,
                                            input logic [3:0] lines);
        logic [15:0] v;
        logic e;
        v = usb_port_pkg::REG_RESET;
        e = code[1];
        if (code[2] && code[0]) begin
            v[usb_port_pkg::PLC_DP_BIT] = lines[e];
            v[usb_port_pkg::PLC_DM_BIT] = lines[2 + int'(e)];
            v[usb_port_pkg::PLC_LOW_SPEED_BIT] = s.lowSpeed[e];
            v[usb_port_pkg::PLC_HOST_ROLE_BIT] = s.hostRole[e];
            v[usb_port_pkg::PLC_RES_EN_BIT] = s.resEn[e];
            v[usb_port_pkg::PLC_FORCE_HI_BIT:usb_port_pkg::PLC_FORCE_LO_BIT] = s.lineForce[e];
            v[usb_port_pkg::PLC_SUSPEND_BIT] = s.suspend[e];
            v[usb_port_pkg::PLC_MARKER_EN_BIT] = s.markerEn[e];
        end else if (code[2]) begin
            v[usb_port_pkg::HTC_PREAMBLE_BIT] = s.preamble[e];
            v[usb_port_pkg::HTC_SEQ_BIT] = s.seqSel[e];
            v[usb_port_pkg::HTC_SYNC_BIT] = s.syncEn[e];
            v[usb_port_pkg::HTC_ISO_BIT] = s.isoEn[e];
            v[usb_port_pkg::HTC_ARM_BIT] = s.arm[e];
        end
        return v;
    endfunction

    logic [2:0] cpuCode;
    logic [2:0] hpiCode;
    assign cpuCode = decodeAddr(cpuAddr);
    assign hpiCode = decodeAddr(hpiAddr);

    // Next-state logic for both engines, registers and line drive.
    always_comb begin
        logic [2:0] wrCode;
        logic [15:0] wrData;
        logic fs;
        n = r;
        wrCode = 3'h0;
        wrData = 16'h0000;
        fs = 1'b0;
        n.pktStart = 2'h0;
        n.preStart = 2'h0;
        n.mrkStart = 2'h0;
        // Both ports read every register file entry.
        n.cpuRd = cpuSel ? readReg(r, cpuCode, lineSync) : 16'h0000;
        n.hpiRd = hpiSel ? readReg(r, hpiCode, lineSync) : 16'h0000;
        for (int e = 0; e < 2; e++) begin
            unique case (usb_port_pkg::seq_state_t'(r.state[e]))
                usb_port_pkg::SEQ_IDLE: begin
                    if (r.suspend[e]) begin
                        n.state[e] = usb_port_pkg::SEQ_IDLE;
                    end else if (r.markerPending[e] && r.hostRole[e] && r.markerEn[e]) begin
                        n.markerPending[e] = 1'b0;
                        n.mrkStart[e] = 1'b1;
                        n.mrkEop[e] = r.lowSpeed[e];
                        n.state[e] = usb_port_pkg::SEQ_MARKER;
                    end else if (r.arm[e] && (!r.syncEn[e] || r.syncReady[e])) begin
                        n.syncReady[e] = 1'b0;
                        n.toggle[e] = r.seqSel[e];
                        n.iso[e] = r.isoEn[e];
                        if (r.preamble[e] && r.lowSpeed[e] && r.hostRole[e]) begin
                            n.preStart[e] = 1'b1;
                            n.state[e] = usb_port_pkg::SEQ_PREAMBLE;
                        end else begin
                            n.pktStart[e] = 1'b1;
                            n.state[e] = usb_port_pkg::SEQ_PACKET;
                        end
                    end
                end
                usb_port_pkg::SEQ_MARKER: begin
                    if (pktDone[e]) begin
                        n.syncReady[e] = 1'b1;
                        n.state[e] = usb_port_pkg::SEQ_IDLE;
                    end
                end
                usb_port_pkg::SEQ_PREAMBLE: begin
                    if (pktDone[e]) begin
                        n.pktStart[e] = 1'b1;
                        n.state[e] = usb_port_pkg::SEQ_PACKET;
                    end
                end
                usb_port_pkg::SEQ_PACKET: begin
                    if (pktDone[e]) begin
                        n.arm[e] = 1'b0;
                        n.state[e] = usb_port_pkg::SEQ_IDLE;
                    end
                end
            endcase
            // Markers only in host role on port A; a new frame beats a serve.
            if (frameTick && r.hostRole[e] && r.markerEn[e] && !portSelectB[e]) begin
                n.markerPending[e] = 1'b1;
            end
            // Register writes; the processor wins over the external port.
            for (int p = 0; p < 2; p++) begin
                wrCode = (p == 0) ? hpiCode : cpuCode;
                wrData = (p == 0) ? hpiWriteData : cpuWriteData;
                if (((p == 0) ? (hpiSel && hpiWrite) : (cpuSel && cpuWrite))
                    && wrCode[2] && (wrCode[1] == e[0])) begin
                    if (wrCode[0]) begin
                        n.lowSpeed[e] = wrData[usb_port_pkg::PLC_LOW_SPEED_BIT];
                        n.hostRole[e] = wrData[usb_port_pkg::PLC_HOST_ROLE_BIT];
                        n.resEn[e] = wrData[usb_port_pkg::PLC_RES_EN_BIT];
                        n.lineForce[e] = wrData[usb_port_pkg::PLC_FORCE_HI_BIT:
                                                usb_port_pkg::PLC_FORCE_LO_BIT];
                        n.suspend[e] = wrData[usb_port_pkg::PLC_SUSPEND_BIT];
                        n.markerEn[e] = wrData[usb_port_pkg::PLC_MARKER_EN_BIT];
                    end else begin
                        n.preamble[e] = wrData[usb_port_pkg::HTC_PREAMBLE_BIT];
                        n.seqSel[e] = wrData[usb_port_pkg::HTC_SEQ_BIT];
                        n.syncEn[e] = wrData[usb_port_pkg::HTC_SYNC_BIT];
                        n.isoEn[e] = wrData[usb_port_pkg::HTC_ISO_BIT];
                        // A software set landing with completion wins.
                        n.arm[e] = wrData[usb_port_pkg::HTC_ARM_BIT] |
                                   (n.arm[e] & r.arm[e] & ~pktDone[e]);
                    end
                end
            end
            // Termination from resistor enable, role and speed.
            n.pdDp[e] = r.resEn[e] && r.hostRole[e];
            n.pdDm[e] = r.resEn[e] && r.hostRole[e];
            n.puDp[e] = r.resEn[e] && !r.hostRole[e] && !r.lowSpeed[e];
            n.puDm[e] = r.resEn[e] && !r.hostRole[e] && r.lowSpeed[e];
            // Line drive; forcing ignores which port is active.
            fs = !r.lowSpeed[e];
            n.rxEn[e] = !r.suspend[e] && !portSelectB[e];
            unique case (usb_port_pkg::line_force_t'(r.lineForce[e]))
                usb_port_pkg::FORCE_NORMAL: begin
                    n.dpDrv[e] = txDp[e];
                    n.dmDrv[e] = txDm[e];
                    n.oeN[e] = !(txActive[e] && !r.suspend[e] && !portSelectB[e]);
                end
                usb_port_pkg::FORCE_SE0: begin
                    n.dpDrv[e] = 1'b0;
                    n.dmDrv[e] = 1'b0;
                    n.oeN[e] = 1'b0;
                end
                usb_port_pkg::FORCE_J: begin
                    n.dpDrv[e] = fs;
                    n.dmDrv[e] = !fs;
                    n.oeN[e] = 1'b0;
                end
                usb_port_pkg::FORCE_K: begin
                    n.dpDrv[e] = !fs;
                    n.dmDrv[e] = fs;
                    n.oeN[e] = 1'b0;
                end
            endcase
        end
    end

    // Single register stage for all control state.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '0;
            r.oeN <= 2'h3;
        end else begin
            r <= n;
        end
    end

    // Outputs come straight from the registered state.
    assign cpuReadData = r.cpuRd;
    assign hpiReadData = r.hpiRd;
    assign dpOut = r.dpDrv;
    assign dmOut = r.dmDrv;
    assign lineOeN = r.oeN;
    assign pullDownDp = r.pdDp;
    assign pullDownDm = r.pdDm;
    assign pullUpDp = r.puDp;
    assign pullUpDm = r.puDm;
    assign xcvrPowerDown = r.suspend;
    assign rxEnable = r.rxEn;
    assign pktStart = r.pktStart;
    assign preambleStart = r.preStart;
    assign markerStart = r.mrkStart;
    assign markerEop = r.mrkEop;
    assign pktToggle = r.toggle;
    assign pktIso = r.iso;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Engine 0 checks; engine 1 shares the same logic.
    a_dp_status_read: assert property (
        cpuSel && cpuAddr == usb_port_pkg::ADDR_PORT_CTRL_1
        |=> cpuReadData[usb_port_pkg::PLC_DP_BIT] == $past(lineSync[0]))
        else $error("D+ status bit does not follow the line.");
    a_dm_status_read: assert property (
        cpuSel && cpuAddr == usb_port_pkg::ADDR_PORT_CTRL_1
        |=> cpuReadData[usb_port_pkg::PLC_DM_BIT] == $past(lineSync[2]))
        else $error("D- status bit does not follow the line.");
    a_pulls_off: assert property (!r.resEn[0] |=> !(pullDownDp[0] || pullDownDm[0]
        || pullUpDp[0] || pullUpDm[0]))
        else $error("Resistor connected while disabled.");
    a_host_pulldowns: assert property (r.resEn[0] && r.hostRole[0]
        |=> pullDownDp[0] && pullDownDm[0] && !pullUpDp[0] && !pullUpDm[0])
        else $error("Host pull-downs wrong.");
    a_device_pullup: assert property (r.resEn[0] && !r.hostRole[0]
        |=> pullUpDm[0] == $past(r.lowSpeed[0]) && pullUpDp[0] == !$past(r.lowSpeed[0]))
        else $error("Device pull-up on wrong line.");
    a_force_j_state: assert property (r.lineForce[0] == usb_port_pkg::FORCE_J
        |=> !lineOeN[0] && dpOut[0] == !$past(r.lowSpeed[0]) && dmOut[0] == $past(r.lowSpeed[0]))
        else $error("Forced J state wrong.");
    a_force_se0_state: assert property (r.lineForce[0] == usb_port_pkg::FORCE_SE0
        |=> !lineOeN[0] && !dpOut[0] && !dmOut[0])
        else $error("Forced SE0 state wrong.");
    a_suspend_blocks: assert property (r.suspend[0] && r.lineForce[0] == 2'h0
        |=> lineOeN[0] && !rxEnable[0] && !pktStart[0])
        else $error("Transfer while suspended.");
    a_marker_kind: assert property (markerStart[0]
        |-> markerEop[0] == $past(r.lowSpeed[0]) && $past(r.hostRole[0] && r.markerEn[0]))
        else $error("Frame marker kind or role wrong.");
    a_preamble_first: assert property (preambleStart[0]
        |-> $past(r.preamble[0] && r.lowSpeed[0]))
        else $error("Preamble without low-speed enable.");
    a_toggle_value: assert property ($rose(pktStart[0]) && $past(r.state[0]) == 2'h0
        |-> pktToggle[0] == $past(r.seqSel[0]))
        else $error("Data toggle does not match sequence bit.");
    a_arm_clear: assert property (r.state[0] == 2'h3 && pktDone[0] && !(cpuSel && cpuWrite)
        && !(hpiSel && hpiWrite) |=> !r.arm[0] ##1 !pktStart[0])
        else $error("Arm not cleared on completion.");
    a_sync_wait: assert property (r.state[0] == 2'h0 && r.arm[0] && r.syncEn[0]
        && !r.syncReady[0] |=> !pktStart[0] && !preambleStart[0])
        else $error("Packet started before the frame marker.");

endmodule

// >>> verif/usb_far_end.sv
`timescale 1ns/1ps
module usb_far_end (
    // Clock.
    input wire logic clock,
    // Peripheral drive commanded by the bench.
    input wire logic [1:0] drvOe,
    input wire logic [1:0] drvDp,
    input wire logic [1:0] drvDm,
    // Block drive and terminations.
    input wire logic [1:0] dpOut,
    input wire logic [1:0] dmOut,
    input wire logic [1:0] lineOeN,
    input wire logic [1:0] pullDownDp,
    input wire logic [1:0] pullDownDm,
    input wire logic [1:0] pullUpDp,
    input wire logic [1:0] pullUpDm,
    // Resolved line levels.
    output logic [1:0] dpIn,
    output logic [1:0] dmIn
);
    logic [1:0] drift = 2'h0;

    // A floating line wanders every cycle, so a stale level is never trusted.
    always @(posedge clock) begin
        drift <= ~drift;
    end

    // Block drive wins, then the peripheral, then the terminations.
    always_comb begin
        for (int e = 0; e < 2; e++) begin
            dpIn[e] = !lineOeN[e] ? dpOut[e] : drvOe[e] ? drvDp[e] :
                pullUpDp[e] ? 1'h1 : pullDownDp[e] ? 1'h0 : drift[e];
            dmIn[e] = !lineOeN[e] ? dmOut[e] : drvOe[e] ? drvDm[e] :
                pullUpDm[e] ? 1'h1 : pullDownDm[e] ? 1'h0 : ~drift[e];
        end
    end
endmodule

// >>> verif/usb_port_line_and_host_control_bench.sv
`timescale 1ns/1ps
module usb_port_line_and_host_control_bench;
    logic clock = 0, sys_rst = 1, cpuSel = 0, cpuWrite = 0, hpiSel = 0, hpiWrite = 0;
    logic [15:0] cpuAddr = 0, cpuWriteData = 0, hpiAddr = 0, hpiWriteData = 0;
    logic [15:0] cpuReadData, hpiReadData;
    logic [1:0] dpIn, dmIn, dpOut, dmOut, lineOeN, pullDownDp, pullDownDm, pullUpDp, pullUpDm;
    logic [1:0] xcvrPowerDown, rxEnable, pktStart, preambleStart, markerStart, markerEop;
    logic [1:0] pktToggle, pktIso, portSelectB = 0, pktDone = 0, drvOe = 2'h3;
    logic [1:0] txDp = 0, txDm = 0, txActive = 0, drvDp = 0, drvDm = 0;
    logic pc = 0, ph = 0;
    logic [15:0] qc[$], qh[$];
    int num_errors = 0, n_tests = 0;
    logic [1:0] r;

    usb_port_line_and_host_control #(.FRAME_CYCLES(50)) DUT (
        .clock(clock), .sys_rst(sys_rst), .cpuSel(cpuSel), .cpuWrite(cpuWrite),
        .cpuAddr(cpuAddr), .cpuWriteData(cpuWriteData), .cpuReadData(cpuReadData),
        .hpiSel(hpiSel), .hpiWrite(hpiWrite), .hpiAddr(hpiAddr),
        .hpiWriteData(hpiWriteData), .hpiReadData(hpiReadData), .dpIn(dpIn), .dmIn(dmIn),
        .dpOut(dpOut), .dmOut(dmOut), .lineOeN(lineOeN), .pullDownDp(pullDownDp),
        .pullDownDm(pullDownDm), .pullUpDp(pullUpDp), .pullUpDm(pullUpDm),
        .xcvrPowerDown(xcvrPowerDown), .rxEnable(rxEnable), .portSelectB(portSelectB),
        .txDp(txDp), .txDm(txDm), .txActive(txActive), .pktDone(pktDone),
        .pktStart(pktStart), .preambleStart(preambleStart), .markerStart(markerStart),
        .markerEop(markerEop), .pktToggle(pktToggle), .pktIso(pktIso));

    usb_far_end far (.clock(clock), .drvOe(drvOe), .drvDp(drvDp), .drvDm(drvDm),
        .dpOut(dpOut), .dmOut(dmOut), .lineOeN(lineOeN), .pullDownDp(pullDownDp),
        .pullDownDm(pullDownDm), .pullUpDp(pullUpDp), .pullUpDm(pullUpDm),
        .dpIn(dpIn), .dmIn(dmIn));

    // The clock toggles every half period of 2.5 ns.
    always #2.5 clock = ~clock;

    // Compares one value and counts the outcome.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    // One register access; on a read the data argument is the expected value.
    task automatic acc(input bit h, input bit w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        if (h) begin
            hpiSel <= 1; hpiWrite <= w; hpiAddr <= a; hpiWriteData <= w ? d : 16'h0;
            if (!w) qh.push_back(d);
        end else begin
            cpuSel <= 1; cpuWrite <= w; cpuAddr <= a; cpuWriteData <= w ? d : 16'h0;
            if (!w) qc.push_back(d);
        end
        @(posedge clock);
        cpuSel <= 0;
        hpiSel <= 0;
        cpuWrite <= 0;
        hpiWrite <= 0;
    endtask

    // Lets registered outputs settle after a write.
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask

    // Waits a bounded time for a start pulse of engine one: 0 packet, 1 marker, 2 preamble.
    task automatic waitOn(input int k);
        for (int i = 0; i < 80; i++) begin
            #1;
            if ((k == 0 && pktStart[0]) || (k == 1 && markerStart[0])) return;
            if (k == 2 && preambleStart[0]) return;
            @(posedge clock);
        end
        $display("[FAIL] %0t start pulse %0d never came", $time, k);
        num_errors++;
        conclude();
    endtask

    // Ends the current unit of work on engine one.
    task automatic done();
        @(posedge clock);
        pktDone <= 2'h1;
        @(posedge clock);
        pktDone <= 2'h0;
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
            chk({15'h0, pktStart[0]}, 16'h0);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Read data answers one cycle after each read strobe.
    always @(posedge clock) begin
        if (pc) chk(cpuReadData, qc.pop_front());
        if (ph) chk(hpiReadData, qh.pop_front());
        pc <= cpuSel && !cpuWrite;
        ph <= hpiSel && !hpiWrite;
    end

    // Main sequence; all software writes keep reserved bits at zero.
    initial begin
        void'($urandom(36));
        repeat (16) @(posedge clock);
        chk({14'h0, lineOeN}, 16'h3);
        sys_rst <= 0;
        acc(0, 0, usb_port_pkg::ADDR_HOST_CTRL_1, 16'h0);
        acc(1, 0, usb_port_pkg::ADDR_PORT_CTRL_1, 16'h0);
        acc(0, 0, usb_port_pkg::ADDR_HOST_CTRL_2, 16'h0);
        acc(0, 0, 16'hc082, 16'h0);
        $display("reset values done");
        repeat (4) begin
            @(posedge clock);
            r = 2'($urandom());
            drvDp <= r;
            drvDm <= ~r;
            repeat (4) @(posedge clock);
            acc(0, 0, usb_port_pkg::ADDR_PORT_CTRL_1, {2'h0, r[0], ~r[0], 12'h0});
            acc(1, 0, usb_port_pkg::ADDR_PORT_CTRL_2, {2'h0, r[1], ~r[1], 12'h0});
        end
        drvDp <= 0;
        drvDm <= 0;
        $display("line status done");
        for (int c = 0; c < 8; c++) begin
            acc(0, 1, usb_port_pkg::ADDR_PORT_CTRL_1, {5'h0, c[2], c[1], 1'h0, c[0], 7'h0});
            settle();
            chk({pullDownDp[0], pullDownDm[0], pullUpDp[0], pullUpDm[0]},
                !c[0] ? 16'h0 : c[1] ? 16'hc : c[2] ? 16'h1 : 16'h2);
        end
        $display("terminations done");
        @(posedge clock);
        portSelectB <= 2'h1;
        for (int s = 0; s < 2; s++) begin
            for (int f = 1; f < 4; f++) begin
                acc(0, 1, usb_port_pkg::ADDR_PORT_CTRL_1, 16'(s << 10 | f << 3));
                settle();
                chk({lineOeN[0], dpOut[0], dmOut[0], rxEnable[0]}, f == 1 ? 16'h0 :
                    ((f == 2) ^ s[0]) ? 16'h4 : 16'h2);
            end
        end
        @(posedge clock);
        portSelectB <= 2'h0;
        $display("line force done");
        acc(1, 1, usb_port_pkg::ADDR_PORT_CTRL_2, 16'h0680);
        acc(0, 0, usb_port_pkg::ADDR_PORT_CTRL_2, 16'h0680);
        #1;
        chk({15'h0, pullDownDp[1]}, 16'h1);
        acc(0, 1, usb_port_pkg::ADDR_PORT_CTRL_1, 16'h0004);
        txActive <= 2'h1;
        txDp <= 2'h1;
        settle();
        chk({13'h0, lineOeN[0], xcvrPowerDown[0], rxEnable[0]}, 16'h6);
        acc(0, 1, usb_port_pkg::ADDR_HOST_CTRL_1, 16'h0001);
        quiet(8);
        acc(0, 1, usb_port_pkg::ADDR_PORT_CTRL_1, 16'h0);
        waitOn(0);
        chk({13'h0, lineOeN[0], dpOut[0], rxEnable[0]}, 16'h3);
        done();
        txActive <= 2'h0;
        $display("suspend and second port done");
        acc(0, 1, usb_port_pkg::ADDR_HOST_CTRL_1, 16'h0051);
        waitOn(0);
        chk({14'h0, pktToggle[0], pktIso[0]}, 16'h3);
        done();
        acc(1, 0, usb_port_pkg::ADDR_HOST_CTRL_1, 16'h0050);
        acc(0, 1, usb_port_pkg::ADDR_HOST_CTRL_1, 16'h0001);
        waitOn(0);
        chk({14'h0, pktToggle[0], pktIso[0]}, 16'h0);
        done();
        $display("transactions done");
        acc(0, 1, usb_port_pkg::ADDR_PORT_CTRL_1, 16'h0600);
        acc(0, 1, usb_port_pkg::ADDR_HOST_CTRL_1, 16'h0081); // preamble with low speed
        waitOn(2);
        done();
        waitOn(0);
        done();
        acc(0, 1, usb_port_pkg::ADDR_PORT_CTRL_1, 16'h0200);
        acc(0, 1, usb_port_pkg::ADDR_HOST_CTRL_1, 16'h0021);
        quiet(60);
        acc(0, 1, usb_port_pkg::ADDR_PORT_CTRL_1, 16'h0201); // marker only in host role
        waitOn(1);
        chk({15'h0, markerEop[0]}, 16'h0);
        done();
        waitOn(0);
        done();
        acc(0, 1, usb_port_pkg::ADDR_PORT_CTRL_1, 16'h0601);
        waitOn(1);
        chk({15'h0, markerEop[0]}, 16'h1);
        done();
        acc(0, 1, usb_port_pkg::ADDR_PORT_CTRL_1, 16'h0);
        $display("markers done");
        repeat (4) @(posedge clock);
        conclude();
    end
endmodule
